// File: hw/insn_decode_pkg.sv
/*
  Shared constants and types for the instruction decode front end:
  class and condition encodings, exception kinds and vectors, field
  positions and the register map of the APB slave.
  Assumes a 32-bit instruction word and a 32-bit APB data path.
*/
package insn_decode_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 12;

  // instruction word field positions
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int TOP_HI  = 27;
  localparam int GRP_LO  = 25;
  localparam int OP5_LO  = 23;
  localparam int OP6_LO  = 22;
  localparam int MID_HI  = 21;
  localparam int MID_LO  = 20;
  localparam int SUB_HI  = 7;
  localparam int SUB_LO  = 4;
  localparam int BIT_IMM = 25;
  localparam int BIT_LNK = 24;
  localparam int BIT_SEL = 22;
  localparam int BIT_S   = 20;
  localparam int BIT_7   = 7;
  localparam int BIT_4   = 4;
  localparam int OPC_HI  = 24;
  localparam int OPC_LO  = 21;
  localparam int RN_LO   = 16;
  localparam int RD_LO   = 12;
  localparam int CP_LO   = 8;
  localparam int RM_LO   = 0;
  localparam int OFS_W   = 24;
  localparam int CPO_W   = 8;

  // class bits 27..25
  localparam logic [2:0] GRP_DP_REG = 3'h0;
  localparam logic [2:0] GRP_DP_IMM = 3'h1;
  localparam logic [2:0] GRP_LS_IMM = 3'h2;
  localparam logic [2:0] GRP_LS_REG = 3'h3;
  localparam logic [2:0] GRP_LDM    = 3'h4;
  localparam logic [2:0] GRP_BRANCH = 3'h5;
  localparam logic [2:0] GRP_COP_LS = 3'h6;
  // sub-patterns inside the groups
  localparam logic [5:0] OP6_MUL   = 6'h00;
  localparam logic [4:0] OP5_LONG  = 5'h01;
  localparam logic [4:0] OP5_MISC  = 5'h02;
  localparam logic [4:0] OP5_MSRI  = 5'h06;
  localparam logic [1:0] MID_READ  = 2'h0;
  localparam logic [1:0] MID_WRITE = 2'h2;
  localparam logic [3:0] NIB_MUL   = 4'h9;
  localparam logic [3:0] NIB_BX    = 4'h1;
  localparam logic [3:0] NIB_ZERO  = 4'h0;

  typedef enum logic [3:0] {
    cond_equal = 4'h0, cond_not_equal = 4'h1,
    cond_carry_set = 4'h2, cond_carry_clear = 4'h3,
    cond_negative = 4'h4, cond_positive_or_zero = 4'h5,
    cond_overflow = 4'h6, cond_no_overflow = 4'h7,
    cond_unsigned_higher = 4'h8, cond_unsigned_lower_same = 4'h9,
    cond_signed_ge = 4'ha, cond_signed_lt = 4'hb,
    cond_signed_gt = 4'hc, cond_signed_le = 4'hd,
    cond_always = 4'he, cond_never = 4'hf
  } cond_t;

  typedef enum logic [4:0] {
    cls_dp_imm, cls_dp_reg, cls_multiply, cls_multiply_long,
    cls_status_read, cls_status_write_reg, cls_status_write_imm,
    cls_branch_exchange, cls_ls_imm, cls_ls_reg, cls_ls_half,
    cls_swap, cls_ls_multiple, cls_cop_data, cls_cop_reg,
    cls_cop_ls, cls_branch, cls_swi, cls_undef, cls_unpredictable
  } class_t;

  typedef enum logic [2:0] {
    exc_none = 3'h0, exc_reset = 3'h1, exc_data_abort = 3'h2,
    exc_fiq = 3'h3, exc_irq = 3'h4, exc_prefetch_abort = 3'h5,
    exc_undef = 3'h6, exc_swi = 3'h7
  } exc_t;

  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_SWI   = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
  localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;

  // status word layout
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam int FLAG_C = 29;
  localparam int FLAG_V = 28;
  localparam int BIT_I  = 7;
  localparam int BIT_F  = 6;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00c0;
  localparam logic [31:0] STATUS_WMASK = 32'hf000_00c0;

  // register map
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_DECODE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_VECTOR = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_INSN   = 12'h00c;
  localparam int DEC_CLASS_LSB = 0;
  localparam int DEC_PASS_BIT  = 8;
  localparam int DEC_EXEC_BIT  = 9;
  localparam int DEC_VALID_BIT = 10;
  localparam int DEC_KIND_LSB  = 12;
  localparam int DEC_DABT_BIT  = 16;
endpackage

// File: hw/insn_class_cond_exc_prio.sv
/*
  Decode front end: sorts each fetched word into its encoding class,
  tests its condition against the status flags and arbitrates the
  pending exceptions by fixed priority. Status and decode state are
  visible over an APB slave.
  Assumes fetch and memory-system inputs are on pclk; interrupt and
  reset request pins are asynchronous and are synchronised here.
*/
// How it works
// - a reset request wins arbitration over everything else
// - data abort ranks below reset and above fast interrupt
// - fast interrupt beats normal interrupt, which beats prefetch abort
// - undefined and software trap rank lowest and never coincide
// - unlisted bit patterns decode as unpredictable, outcome unchecked
// - condition comes from bits 31 to 28 before other decoding
// - condition tested against N Z C V; failing words have no effect
// - condition 1110 always executes
// - condition 1111 is unpredictable; here it never executes
// - 0000/0001 test Z set/clear, 0100/0101 test N set/clear
// - 0010/0011 test C set/clear, 0110/0111 test V set/clear
// - 1000 needs C set and Z clear; 1001 C clear or Z set
// - 1010 needs N equal V; 1011 N differs from V
// - 1100 needs Z clear and N equal V; 1101 the inverse
// - class 001 is immediate data processing, 000 register form
// - status register read and write encodings with select and mask
// - class 101 is branch with 24-bit offset and link bit
// - class 110 is coprocessor load or store with 8-bit offset
// - the winning exception drives its fixed vector
module insn_class_cond_exc_prio (
  input  wire logic                                  pclk,               // core clock
  input  wire logic                                  presetn,            // async reset
  input  wire logic                                  psel,               // apb select
  input  wire logic                                  penable,            // apb enable
  input  wire logic                                  pwrite,             // apb direction
  input  wire logic [insn_decode_pkg::ADDR_W-1:0]    paddr,              // apb address
  input  wire logic [insn_decode_pkg::WORD_W-1:0]    pwdata,             // apb write data
  output logic      [insn_decode_pkg::WORD_W-1:0]    prdata,             // apb read data
  output logic                                       pready,             // apb ready
  output logic                                       pslverr,            // apb error
  input  wire logic                                  insn_valid,         // fetch word valid
  input  wire logic [insn_decode_pkg::WORD_W-1:0]    insn_word,          // fetched word
  input  wire logic                                  insn_fetch_abort,   // word fetch aborted
  input  wire logic                                  data_abort,         // data access abort
  input  wire logic                                  fiq_pin,            // fast irq request
  input  wire logic                                  irq_pin,            // irq request
  input  wire logic                                  reset_pin,          // reset request
  output logic                                       dec_valid,          // decode outputs valid
  output insn_decode_pkg::class_t                    dec_class,          // encoding class
  output logic                                       cond_pass,          // condition passed
  output logic                                       insn_exec,          // word takes effect
  output logic      [3:0]                            dec_opcode,         // alu opcode
  output logic                                       dec_set_flags,      // flag update bit
  output logic      [3:0]                            first_operand_reg,  // first operand
  output logic      [3:0]                            dest_reg,           // destination
  output logic      [3:0]                            second_operand_reg, // second operand
  output logic                                       dec_link,           // save return address
  output logic      [insn_decode_pkg::OFS_W-1:0]     branch_offset,      // branch offset
  output logic      [3:0]                            coprocessor_number, // coprocessor id
  output logic      [insn_decode_pkg::CPO_W-1:0]     cop_offset,         // coprocessor offset
  output logic      [4:0]                            cop_mode_bits,      // index/dir/len/wb/ld
  output logic                                       status_select,      // saved status sel
  output logic      [3:0]                            status_mask,        // write field mask
  output logic                                       exc_take,           // exception entered
  output insn_decode_pkg::exc_t                      exc_kind,           // which exception
  output logic      [insn_decode_pkg::WORD_W-1:0]    exc_vector          // vector address
);
  import insn_decode_pkg::*;

  function automatic logic cond_check(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v, r;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    case (cond_t'(c))
      cond_equal:               r = z;
      cond_not_equal:           r = !z;
      cond_carry_set:           r = cy;
      cond_carry_clear:         r = !cy;
      cond_negative:            r = n;
      cond_positive_or_zero:    r = !n;
      cond_overflow:            r = v;
      cond_no_overflow:         r = !v;
      cond_unsigned_higher:     r = cy && !z;
      cond_unsigned_lower_same: r = !cy || z;
      cond_signed_ge:           r = (n == v);
      cond_signed_lt:           r = (n != v);
      cond_signed_gt:           r = !z && (n == v);
      cond_signed_le:           r = z || (n != v);
      cond_always:              r = 1'b1;
      default:                  r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic class_t classify(input logic [31:0] w);
    class_t     c;
    logic [4:0] op5;
    logic [1:0] mid;
    logic [3:0] sub;
    op5 = w[TOP_HI:OP5_LO];
    mid = w[MID_HI:MID_LO];
    sub = w[SUB_HI:SUB_LO];
    c   = cls_unpredictable;
    case (w[TOP_HI:GRP_LO])
      GRP_DP_REG: begin
        if (sub == NIB_MUL && w[TOP_HI:OP6_LO] == OP6_MUL)
          c = cls_multiply;
        else if (sub == NIB_MUL && op5 == OP5_LONG)
          c = cls_multiply_long;
        else if (sub == NIB_MUL && op5 == OP5_MISC && mid == MID_READ)
          c = cls_swap;
        else if (w[BIT_7] && w[BIT_4])
          c = (sub == NIB_MUL) ? cls_unpredictable : cls_ls_half;
        else if (op5 == OP5_MISC && mid == MID_WRITE && sub == NIB_BX)
          c = cls_branch_exchange;
        else if (op5 == OP5_MISC && mid == MID_READ && sub == NIB_ZERO)
          c = cls_status_read;
        else if (op5 == OP5_MISC && mid == MID_WRITE && !w[BIT_4])
          c = cls_status_write_reg;
        else if (op5 != OP5_MISC || w[BIT_S])
          c = cls_dp_reg;
      end
      GRP_DP_IMM: begin
        if (op5 == OP5_MSRI && mid == MID_WRITE)
          c = cls_status_write_imm;
        else if (op5 != OP5_MSRI || w[BIT_S])
          c = cls_dp_imm;
      end
      GRP_LS_IMM: c = cls_ls_imm;
      GRP_LS_REG: c = w[BIT_4] ? cls_undef : cls_ls_reg;
      GRP_LDM:    c = cls_ls_multiple;
      GRP_BRANCH: c = cls_branch;
      GRP_COP_LS: c = cls_cop_ls;
      default:    c = w[BIT_LNK] ? cls_swi : (w[BIT_4] ? cls_cop_reg : cls_cop_data);
    endcase
    return c;
  endfunction

  function automatic logic [31:0] vector_of(input exc_t k);
    case (k)
      exc_undef:          return VEC_UNDEF;
      exc_swi:            return VEC_SWI;
      exc_prefetch_abort: return VEC_PABT;
      exc_data_abort:     return VEC_DABT;
      exc_irq:            return VEC_IRQ;
      exc_fiq:            return VEC_FIQ;
      default:            return VEC_RESET;
    endcase
  endfunction

  // request pins: {reset, fiq, irq}
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic [31:0] status_word;
  logic        da_pend;
  logic [31:0] dec_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {reset_pin, fiq_pin, irq_pin};
      pin_sync <= pin_meta;
    end
  end

  wire [3:0] cond_field = insn_word[COND_HI:COND_LO];
  wire [3:0] nzcv       = status_word[FLAG_N:FLAG_V];
  wire       pass_now   = cond_check(cond_field, nzcv);
  wire       cls_is_und;
  wire       cls_is_swi;
  class_t    cls_now;
  assign cls_now    = classify(insn_word);
  assign cls_is_und = (cls_now == cls_undef);
  assign cls_is_swi = (cls_now == cls_swi);

  // requests seen together at an instruction boundary
  wire rst_req   = pin_sync[2];
  wire da_any    = da_pend || data_abort;
  wire fiq_req   = pin_sync[1] && !status_word[BIT_F];
  wire irq_req   = pin_sync[0] && !status_word[BIT_I];
  wire pa_req    = insn_valid && insn_fetch_abort;
  wire run_ok    = insn_valid && !insn_fetch_abort && pass_now;
  wire undef_req = run_ok && cls_is_und;
  wire swi_req   = run_ok && cls_is_swi;

  exc_t next_kind;
  assign next_kind = rst_req    ? exc_reset          :
                     !insn_valid ? exc_none          :
                     da_any     ? exc_data_abort     :
                     fiq_req    ? exc_fiq            :
                     irq_req    ? exc_irq            :
                     pa_req     ? exc_prefetch_abort :
                     undef_req  ? exc_undef          :
                     swi_req    ? exc_swi : exc_none;

  wire take_da  = (next_kind == exc_data_abort);
  // an abort already pending and a new one in the take cycle: keep one
  wire next_da  = !rst_req && ((da_pend && data_abort) || (da_any && !take_da));
  wire next_run = run_ok && (next_kind == exc_none);

  // apb decode
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_decode = (paddr == OFS_DECODE);
  wire hit_vector = (paddr == OFS_VECTOR);
  wire hit_insn   = (paddr == OFS_INSN);
  wire mapped     = hit_status || hit_decode || hit_vector || hit_insn;
  wire wr_status  = psel && penable && pwrite && hit_status;
  wire rd_setup   = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  logic [31:0] decode_view;
  always_comb begin
    decode_view = '0;
    decode_view[DEC_CLASS_LSB +: 5] = dec_class;
    decode_view[DEC_PASS_BIT]       = cond_pass;
    decode_view[DEC_EXEC_BIT]       = insn_exec;
    decode_view[DEC_VALID_BIT]      = dec_valid;
    decode_view[DEC_KIND_LSB +: 3]  = exc_kind;
    decode_view[DEC_DABT_BIT]       = da_pend;
  end

  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_decode ? decode_view :
                       hit_vector ? exc_vector  :
                       hit_insn   ? dec_word    : '0;

  // entry masks interrupts; reset and fiq entry also mask fiq
  wire        mask_i   = (next_kind != exc_none);
  wire        mask_f   = (next_kind == exc_reset) || (next_kind == exc_fiq);
  wire [31:0] sw_value = wr_status ? ((status_word & ~STATUS_WMASK) | (pwdata & STATUS_WMASK))
                                   : status_word;
  wire [31:0] next_status = sw_value | ({31'h0, mask_i} << BIT_I) | ({31'h0, mask_f} << BIT_F);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= STATUS_RESET;
      da_pend     <= 1'b0;
      prdata      <= '0;
    end else begin
      status_word <= next_status;
      da_pend     <= next_da;
      if (rd_setup)
        prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_take   <= 1'b0;
      exc_kind   <= exc_none;
      exc_vector <= VEC_RESET;
    end else begin
      exc_take   <= (next_kind != exc_none);
      exc_kind   <= next_kind;
      exc_vector <= vector_of(next_kind);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid <= 1'b0;
      cond_pass <= 1'b0;
      insn_exec <= 1'b0;
      dec_class <= cls_unpredictable;
      dec_word  <= '0;
    end else begin
      dec_valid <= insn_valid;
      insn_exec <= next_run;
      if (insn_valid) begin
        cond_pass <= pass_now;
        dec_class <= cls_now;
        dec_word  <= insn_word;
      end
    end
  end

  // field views of the held word
  assign dec_opcode         = dec_word[OPC_HI:OPC_LO];
  assign dec_set_flags      = dec_word[BIT_S];
  assign first_operand_reg  = dec_word[RN_LO +: 4];
  assign dest_reg           = dec_word[RD_LO +: 4];
  assign second_operand_reg = dec_word[RM_LO +: 4];
  assign dec_link           = dec_word[BIT_LNK];
  assign branch_offset      = dec_word[OFS_W-1:0];
  assign coprocessor_number = dec_word[CP_LO +: 4];
  assign cop_offset         = dec_word[CPO_W-1:0];
  assign cop_mode_bits      = dec_word[OPC_HI:MID_LO];
  assign status_select      = dec_word[BIT_SEL];
  assign status_mask        = dec_word[RN_LO +: 4];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_WINS: assert property (
    rst_req |=> exc_take && exc_kind == exc_reset && exc_vector == VEC_RESET)
    else $error("reset request not taken first");
  AST_DABT_OVER_FIQ: assert property (
    !rst_req && insn_valid && da_any && fiq_req |=> exc_kind == exc_data_abort)
    else $error("data abort lost to fast interrupt");
  AST_FIQ_OVER_IRQ: assert property (
    !rst_req && insn_valid && !da_any && fiq_req && irq_req |=> exc_kind == exc_fiq)
    else $error("fast interrupt lost to interrupt");
  AST_IRQ_OVER_PABT: assert property (
    !rst_req && insn_valid && !da_any && !fiq_req && irq_req && pa_req
    |=> exc_kind == exc_irq && exc_vector == VEC_IRQ)
    else $error("interrupt lost to prefetch abort");
  AST_LOW_PRIO: assert property (
    exc_take && (exc_kind == exc_undef || exc_kind == exc_swi)
    |-> !$past(fiq_req) && !$past(irq_req) && !$past(pa_req) && !$past(da_any) && !insn_exec)
    else $error("low priority trap taken over a higher one");
  AST_FAIL_NO_EFFECT: assert property (
    dec_valid && !cond_pass |-> !insn_exec)
    else $error("failed condition still took effect");
  AST_ALWAYS: assert property (
    insn_valid && cond_field == cond_always |=> cond_pass)
    else $error("always condition did not pass");
  AST_ZERO_NEG: assert property (
    insn_valid && cond_field[3:1] == 3'h0
    |=> cond_pass == ($past(status_word[FLAG_Z]) ^ $past(cond_field[0])))
    else $error("zero flag condition wrong");
  AST_CARRY: assert property (
    insn_valid && cond_field == cond_carry_clear |=> cond_pass == !$past(status_word[FLAG_C]))
    else $error("carry clear condition wrong");
  AST_HIGHER: assert property (
    insn_valid && cond_field == cond_unsigned_higher
    |=> cond_pass == ($past(nzcv[1]) && !$past(nzcv[2])))
    else $error("unsigned higher condition wrong");
  AST_SIGNED: assert property (
    insn_valid && cond_field == cond_signed_lt |=> cond_pass == ($past(nzcv[3]) != $past(nzcv[0])))
    else $error("signed less condition wrong");
  AST_GREATER: assert property (
    insn_valid && cond_field == cond_signed_gt
    |=> cond_pass == (!$past(nzcv[2]) && $past(nzcv[3]) == $past(nzcv[0])))
    else $error("signed greater condition wrong");
  AST_BRANCH: assert property (
    insn_valid && insn_word[TOP_HI:GRP_LO] == GRP_BRANCH
    |=> dec_class == cls_branch && branch_offset == $past(insn_word[OFS_W-1:0]))
    else $error("branch not decoded");
  AST_VECTOR: assert property (
    exc_take && exc_kind == exc_fiq |-> exc_vector == VEC_FIQ && status_word[BIT_F])
    else $error("fast interrupt vector or mask wrong");
  AST_DABT_KEPT: assert property (
    !rst_req && !insn_valid && data_abort |=> da_pend && !exc_take)
    else $error("pending data abort dropped");

  AST_PABT_TAKEN: assert property (
    !rst_req && insn_valid && !da_any && !fiq_req && !irq_req && pa_req
    |=> exc_kind == exc_prefetch_abort && exc_vector == VEC_PABT)
    else $error("prefetch abort not taken");

  AST_DP_IMM: assert property (
    insn_valid && insn_word[TOP_HI:GRP_LO] == GRP_DP_IMM && insn_word[TOP_HI:OP5_LO] != OP5_MSRI
    |=> dec_class == cls_dp_imm)
    else $error("immediate data processing not decoded");

  AST_MUL_CLASS: assert property (
    insn_valid && insn_word[TOP_HI:OP6_LO] == OP6_MUL && insn_word[SUB_HI:SUB_LO] == NIB_MUL
    |=> dec_class == cls_multiply)
    else $error("multiply not decoded");

  AST_UNDEF_CLASS: assert property (
    insn_valid && insn_word[TOP_HI:GRP_LO] == GRP_LS_REG && insn_word[BIT_4]
    |=> dec_class == cls_undef)
    else $error("undefined word not decoded");

  AST_COP_CLASS: assert property (
    insn_valid && insn_word[TOP_HI:GRP_LO] == GRP_COP_LS |=> dec_class == cls_cop_ls)
    else $error("coprocessor transfer not decoded");
endmodule

// File: tb/fetch_model.sv
/* fetch stage, memory system and request pins seen from the decoder.
   assumes the bench calls its tasks, all on pclk */
module fetch_model (
  input  wire logic        pclk,             // core clock
  output logic             insn_valid,       // word valid
  output logic [31:0]      insn_word,        // fetched word
  output logic             insn_fetch_abort, // fetch aborted
  output logic             data_abort,       // data abort pulse
  output logic             fiq_pin,          // fast request
  output logic             irq_pin,          // normal request
  output logic             reset_pin         // reset request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {insn_valid, insn_fetch_abort, data_abort, fiq_pin, irq_pin, reset_pin} = 6'h00;
    insn_word = 32'h0;
  end
  task automatic issue(input logic [31:0] w, input logic abt);
    @(posedge pclk);
    insn_valid       <= 1'b1;
    insn_word        <= w;
    insn_fetch_abort <= abt;
    @(posedge pclk);
    insn_valid       <= 1'b0;
    insn_word        <= ~w; // released bus does not keep the word
    insn_fetch_abort <= 1'b0;
  endtask
  task automatic requests(input logic d, input logic f, input logic i, input logic r);
    @(posedge pclk);
    {data_abort, fiq_pin, irq_pin, reset_pin} <= {d, f, i, r};
    @(posedge pclk);
    data_abort <= 1'b0;
  endtask
endmodule

// File: tb/testbench.sv
/* self-checking bench: condition table, class decode, exception priority.
   assumes the decoder's one-cycle answer and zero-wait apb slave */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import insn_decode_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, iv, abt, dabt, fq, iq, rq;
  logic cpass, exec, take, link, sflag, ssel, dv, serr;
  logic [3:0] opc, rn, rd, rm, smask;
  logic [4:0] cmode;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, word, vec, rdata;
  logic [23:0] ofs;
  logic [7:0] cofs;
  logic [3:0] cpn;
  class_t cls;
  exc_t kind;
  int bad_count = 0;
  int comparisons = 0;
  fetch_model partner_u (.pclk(pclk), .insn_valid(iv), .insn_word(word),
    .insn_fetch_abort(abt), .data_abort(dabt), .fiq_pin(fq), .irq_pin(iq), .reset_pin(rq));
  insn_class_cond_exc_prio dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rdata),
    .pready(pready), .pslverr(serr), .insn_valid(iv), .insn_word(word), .insn_fetch_abort(abt),
    .data_abort(dabt), .fiq_pin(fq), .irq_pin(iq), .reset_pin(rq), .dec_valid(dv),
    .dec_class(cls), .cond_pass(cpass), .insn_exec(exec), .dec_opcode(opc),
    .dec_set_flags(sflag), .first_operand_reg(rn), .dest_reg(rd), .second_operand_reg(rm),
    .dec_link(link), .branch_offset(ofs), .coprocessor_number(cpn), .cop_offset(cofs),
    .cop_mode_bits(cmode), .status_select(ssel), .status_mask(smask), .exc_take(take),
    .exc_kind(kind), .exc_vector(vec));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, penable} <= 3'h6;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic apb_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic e);
    @(posedge pclk);
    {psel, pwrite, penable} <= 3'h4;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = rdata;
    e = serr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic reg_access;
    logic [31:0] d;
    logic e;
    apb_write(OFS_STATUS, 32'hffff_ffff);
    apb_read(OFS_STATUS, d, e);
    check({e, d}, {1'b0, STATUS_WMASK}, "status readback");
    apb_read(12'h010, d, e);
    check({e, d}, {1'b1, 32'h0}, "unmapped read");
  endtask
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    case (c)
      4'h0: return f[2];               4'h1: return !f[2];
      4'h2: return f[1];               4'h3: return !f[1];
      4'h4: return f[3];               4'h5: return !f[3];
      4'h6: return f[0];               4'h7: return !f[0];
      4'h8: return f[1] && !f[2];      4'h9: return !f[1] || f[2];
      4'ha: return f[3] == f[0];       4'hb: return f[3] != f[0];
      4'hc: return !f[2] && (f[3] == f[0]);
      4'hd: return f[2] || (f[3] != f[0]);
      default: return 1'b1;
    endcase
  endfunction
  task automatic cond_table;
    for (int c = 0; c < 15; c++) begin
      for (int f = 0; f < 16; f++) begin
        apb_write(OFS_STATUS, {f[3:0], 28'h0});
        partner_u.issue({c[3:0], 28'ha000000}, 1'b0);
        #1 check(cpass, cond_ok(c[3:0], f[3:0]), "condition result");
        check(exec, cond_ok(c[3:0], f[3:0]), "execute flag");
      end
    end
  endtask
  task automatic class_table;
    logic [31:0] w [7] = '{32'he3a01005, 32'he0812003, 32'he0010392, 32'he10f0000,
                           32'heb000010, 32'hed912305, 32'he1530001};
    class_t k [7] = '{cls_dp_imm, cls_dp_reg, cls_multiply, cls_status_read, cls_branch,
                      cls_cop_ls, cls_dp_reg};
    for (int i = 0; i < 7; i++) begin
      partner_u.issue(w[i], 1'b0);
      #1 check({dv, cls}, {1'b1, k[i]}, "class");
      if (i == 1) check({opc, sflag, rn, rd, rm}, 17'h08123, "operand fields");
      if (i == 3) check({ssel, smask}, 5'h0f, "status fields");
      if (i == 4) check({link, ofs}, 25'h1000010, "branch fields");
      if (i == 5) check({cmode, cpn, cofs}, 17'h19305, "coprocessor fields");
    end
  endtask
  task automatic prio(input logic [3:0] req, input logic [31:0] w, input exc_t k,
                      input logic [31:0] v);
    apb_write(OFS_STATUS, 32'h0);
    partner_u.requests(req[3], req[2], req[1], 1'b0);
    repeat (3) @(posedge pclk);
    partner_u.issue(w, req[0]);
    #1 check({take, kind, v}, {1'b1, k, vec}, "exception winner");
    partner_u.requests(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = '0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cond_table();
    class_table();
    prio(4'hf, 32'he7f000f0, exc_data_abort, VEC_DABT);
    prio(4'h7, 32'he7f000f0, exc_fiq, VEC_FIQ);
    prio(4'h3, 32'he7f000f0, exc_irq, VEC_IRQ);
    prio(4'h1, 32'he7f000f0, exc_prefetch_abort, VEC_PABT);
    prio(4'h0, 32'he7f000f0, exc_undef, VEC_UNDEF);
    prio(4'h0, 32'hef000000, exc_swi, VEC_SWI);
    reg_access();
    partner_u.requests(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    #1 check({kind, vec}, {exc_reset, VEC_RESET}, "reset wins");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report();
  end
endmodule
